// ---- common/eeprom_target_pkg.sv ----
// Purpose: shared constants and types of the serial eeprom bus target
// Assumes: 10 MHz core clock
// Notes:   write cycle count is a top-level parameter default
package eeprom_target_pkg;

  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          WRITE_TIME_MS    = 5;
  // longest time: integer division rounds down
  localparam logic [15:0] WRITE_CYCLES_DEF = 16'(WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS);

  localparam int          ARRAY_AW         = 13;
  localparam int          PAGE_AW          = 5;
  localparam int          PAGE_BYTES       = 32;
  localparam int          ARRAY_BYTES      = 8192;
  localparam int          HI_ADDR_W        = 5;

  localparam logic [3:0]  TYPE_MAIN        = 4'hA;
  localparam logic [3:0]  TYPE_ID          = 4'hB;
  localparam logic [3:0]  BIT_ACK          = 4'h8;
  localparam logic [3:0]  BIT_ZERO         = 4'h0;
  localparam int          LOCK_SEL_POS     = 2;
  localparam int          LOCK_DATA_POS    = 1;
  localparam logic [4:0]  PAGE_LAST        = 5'h1F;
  localparam logic [12:0] ARRAY_LAST       = 13'h1FFF;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DEV    = 3'b001,
    ST_ADDR_H = 3'b010,
    ST_ADDR_L = 3'b011,
    ST_WDATA  = 3'b100,
    ST_READ   = 3'b101,
    ST_IGNORE = 3'b110
  } bus_state_t;

endpackage

// ---- hw/bus_sync.sv ----
// Purpose: two-stage synchronisers for the bus pins and edge/condition detect
// Assumes: pins are asynchronous to core_clk
// Notes:   edges are taken between the second and third stage only
`timescale 1ns/100ps
module bus_sync
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  input  wire logic       wp,
  input  wire logic [2:0] cs,
  output logic            sda_s,
  output logic            scl_rise,
  output logic            scl_fall,
  output logic            start_det,
  output logic            stop_det,
  output logic            wp_s,
  output logic [2:0]      cs_s
);

  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic [5:0] meta_next;
  logic [5:0] sync_next;

  always_comb
  begin
    meta_next = {cs, wp, sda_in, scl};
    sync_next = meta_reg;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg  <= 6'h03;
      sync_reg  <= 6'h03;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      meta_reg  <= meta_next;
      sync_reg  <= sync_next;
      scl_d_reg <= sync_reg[0];
      sda_d_reg <= sync_reg[1];
    end
  end

  assign sda_s     = sync_reg[1];
  assign wp_s      = sync_reg[2];
  assign cs_s      = sync_reg[5:3];
  assign scl_rise  = sync_reg[0] & ~scl_d_reg;
  assign scl_fall  = ~sync_reg[0] & scl_d_reg;
  // sda moving while scl stays high marks a frame boundary
  assign start_det = sync_reg[0] & scl_d_reg & sda_d_reg & ~sync_reg[1];
  assign stop_det  = sync_reg[0] & scl_d_reg & ~sda_d_reg & sync_reg[1];

endmodule

// ---- hw/eeprom_bus_target.sv ----
// Purpose: two-wire bus target of a 64-kilobit byte-wide serial eeprom
// Assumes: scl well below core_clk / 6; sda is open drain, external pull-up
// Notes:   cell programming is modelled by a timed commit of the page buffer
`timescale 1ns/100ps
module eeprom_bus_target
  import eeprom_target_pkg::*;
#(
  parameter logic [15:0] WRITE_CYCLES = eeprom_target_pkg::WRITE_CYCLES_DEF
)
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic chip_select_bit0,
  input  wire logic chip_select_bit1,
  input  wire logic chip_select_bit2,
  input  wire logic write_protect,
  output logic      write_busy,
  output logic      id_locked,
  output logic      standby
);

  import eeprom_target_pkg::*;

  function automatic logic [ARRAY_AW-1:0] page_inc(input logic [ARRAY_AW-1:0] a);
    page_inc = {a[ARRAY_AW-1:PAGE_AW], 5'(a[PAGE_AW-1:0] + 5'h01)};
  endfunction

  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       wp_s;
  logic [2:0] cs_s;

  bus_sync u_sync
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .scl       (scl),
    .sda_in    (sda_in),
    .wp        (write_protect),
    .cs        ({chip_select_bit2, chip_select_bit1, chip_select_bit0}),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .wp_s      (wp_s),
    .cs_s      (cs_s)
  );

  logic [7:0]           mem       [ARRAY_BYTES];
  logic [7:0]           id_mem    [PAGE_BYTES];
  logic [7:0]           page_buf  [PAGE_BYTES];

  bus_state_t           state_reg, state_next, after_reg, after_next;
  logic [3:0]           cnt_reg, cnt_next;
  logic                 ackph_reg, ackph_next;
  logic                 mack_reg, mack_next;
  logic [7:0]           shift_reg, shift_next;
  logic [7:0]           tx_reg, tx_next;
  logic [ARRAY_AW-1:0]  addr_reg, addr_next;
  logic [HI_ADDR_W-1:0] hi_reg, hi_next;
  logic                 is_id_reg, is_id_next;
  logic                 oe_reg, oe_next;
  logic                 pend_reg, pend_next;
  logic                 lock_arm_reg, lock_arm_next;
  logic [PAGE_BYTES-1:0] mask_reg, mask_next;
  logic                 prog_id_reg, prog_id_next;
  logic [7:0]           prog_page_reg, prog_page_next;
  logic                 busy_reg, busy_next;
  logic [15:0]          timer_reg, timer_next;
  logic                 locked_reg, locked_next;
  logic                 standby_reg, standby_next;
  logic                 buf_we;
  logic                 do_load;
  logic                 commit;
  logic                 ok;
  logic [7:0]           rd_byte;

  always_comb
  begin
    state_next     = state_reg;
    after_next     = after_reg;
    cnt_next       = cnt_reg;
    ackph_next     = ackph_reg;
    mack_next      = mack_reg;
    shift_next     = shift_reg;
    tx_next        = tx_reg;
    addr_next      = addr_reg;
    hi_next        = hi_reg;
    is_id_next     = is_id_reg;
    oe_next        = oe_reg;
    pend_next      = pend_reg;
    lock_arm_next  = lock_arm_reg;
    mask_next      = mask_reg;
    prog_id_next   = prog_id_reg;
    prog_page_next = prog_page_reg;
    busy_next      = busy_reg;
    timer_next     = timer_reg;
    locked_next    = locked_reg;
    buf_we         = 1'b0;
    do_load        = 1'b0;
    ok             = 1'b0;
    commit         = busy_reg && timer_reg == 16'h0001;
    rd_byte        = is_id_reg ? id_mem[addr_reg[PAGE_AW-1:0]] : mem[addr_reg];

    if (busy_reg)
    begin
      timer_next = 16'(timer_reg - 16'h0001);
      if (commit)
      begin
        busy_next = 1'b0;
        if (prog_id_reg && lock_arm_reg)
          locked_next = 1'b1;
      end
    end

    if (start_det)
    begin
      state_next = ST_DEV;
      cnt_next   = BIT_ZERO;
      ackph_next = 1'b0;
      oe_next    = 1'b0;
    end
    else if (stop_det)
    begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
      ackph_next = 1'b0;
      pend_next  = 1'b0;
      // write protect suppresses the cycle; bytes were still acked
      if (state_reg == ST_WDATA && pend_reg && !wp_s && !busy_reg)
      begin
        busy_next      = 1'b1;
        timer_next     = WRITE_CYCLES;
        prog_id_next   = is_id_reg;
        prog_page_next = addr_reg[ARRAY_AW-1:PAGE_AW];
      end
    end
    else if (scl_rise)
    begin
      case (state_reg)
        ST_DEV, ST_ADDR_H, ST_ADDR_L, ST_WDATA:
          if (!ackph_reg && cnt_reg != BIT_ACK)
          begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = 4'(cnt_reg + 4'h1);
          end
        ST_READ:
          if (cnt_reg != BIT_ACK)
            cnt_next = 4'(cnt_reg + 4'h1);
          else if (ackph_reg)
            mack_next = ~sda_s;
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_reg)
        ST_DEV, ST_ADDR_H, ST_ADDR_L, ST_WDATA:
          if (ackph_reg)
          begin
            oe_next    = 1'b0;
            ackph_next = 1'b0;
            cnt_next   = BIT_ZERO;
            state_next = after_reg;
            do_load    = after_reg == ST_READ;
          end
          else if (cnt_reg == BIT_ACK)
          begin
            case (state_reg)
              ST_DEV:
              begin
                // polling during programming finds no answer
                ok = (shift_reg[7:4] == TYPE_MAIN || shift_reg[7:4] == TYPE_ID)
                     && shift_reg[3:1] == cs_s && !busy_reg;
                if (ok)
                begin
                  is_id_next = shift_reg[7:4] == TYPE_ID;
                  after_next = shift_reg[0] ? ST_READ : ST_ADDR_H;
                end
              end
              ST_ADDR_H:
              begin
                ok         = 1'b1;
                hi_next    = shift_reg[HI_ADDR_W-1:0];
                after_next = ST_ADDR_L;
              end
              ST_ADDR_L:
              begin
                ok            = 1'b1;
                addr_next     = {hi_reg, shift_reg};
                mask_next     = '0;
                pend_next     = 1'b0;
                lock_arm_next = 1'b0;
                after_next    = ST_WDATA;
              end
              ST_WDATA:
              begin
                ok         = !(is_id_reg && locked_reg);
                after_next = ST_WDATA;
                if (ok)
                begin
                  pend_next = 1'b1;
                  if (is_id_reg && hi_reg[LOCK_SEL_POS])
                    lock_arm_next = lock_arm_reg | shift_reg[LOCK_DATA_POS];
                  else
                  begin
                    buf_we                             = 1'b1;
                    mask_next[addr_reg[PAGE_AW-1:0]]   = 1'b1;
                    addr_next                          = page_inc(addr_reg);
                  end
                end
              end
              default: ;
            endcase
            oe_next = ok;
            if (ok)
              ackph_next = 1'b1;
            else
              state_next = ST_IGNORE;
          end
        ST_READ:
          if (ackph_reg)
          begin
            if (mack_reg)
              do_load = 1'b1;
            else
            begin
              state_next = ST_IGNORE;
              oe_next    = 1'b0;
            end
          end
          else if (cnt_reg == BIT_ACK)
          begin
            oe_next    = 1'b0;
            ackph_next = 1'b1;
            mack_next  = 1'b0;
          end
          else
            oe_next = ~tx_reg[3'(3'd7 - cnt_reg[2:0])];
        default: ;
      endcase
    end

    if (do_load)
    begin
      tx_next    = rd_byte;
      oe_next    = ~rd_byte[7];
      cnt_next   = BIT_ZERO;
      ackph_next = 1'b0;
      // id page reads stay inside their page; the array wraps at its end
      addr_next  = is_id_reg ? page_inc(addr_reg) : 13'(addr_reg + 13'h0001);
    end

    standby_next = state_next == ST_IDLE && !busy_next;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg     <= ST_IDLE;
      after_reg     <= ST_IDLE;
      cnt_reg       <= BIT_ZERO;
      ackph_reg     <= 1'b0;
      mack_reg      <= 1'b0;
      shift_reg     <= 8'h00;
      tx_reg        <= 8'h00;
      addr_reg      <= 13'h0000;
      hi_reg        <= 5'h00;
      is_id_reg     <= 1'b0;
      oe_reg        <= 1'b0;
      pend_reg      <= 1'b0;
      lock_arm_reg  <= 1'b0;
      mask_reg      <= 32'h00000000;
      prog_id_reg   <= 1'b0;
      prog_page_reg <= 8'h00;
      busy_reg      <= 1'b0;
      timer_reg     <= 16'h0000;
      locked_reg    <= 1'b0;
      standby_reg   <= 1'b1;
    end
    else
    begin
      state_reg     <= state_next;
      after_reg     <= after_next;
      cnt_reg       <= cnt_next;
      ackph_reg     <= ackph_next;
      mack_reg      <= mack_next;
      shift_reg     <= shift_next;
      tx_reg        <= tx_next;
      addr_reg      <= addr_next;
      hi_reg        <= hi_next;
      is_id_reg     <= is_id_next;
      oe_reg        <= oe_next;
      pend_reg      <= pend_next;
      lock_arm_reg  <= lock_arm_next;
      mask_reg      <= mask_next;
      prog_id_reg   <= prog_id_next;
      prog_page_reg <= prog_page_next;
      busy_reg      <= busy_next;
      timer_reg     <= timer_next;
      locked_reg    <= locked_next;
      standby_reg   <= standby_next;
    end
  end

  // cell arrays are nonvolatile, so they take no reset
  always_ff @(posedge core_clk)
  begin
    if (buf_we)
      page_buf[addr_reg[PAGE_AW-1:0]] <= shift_reg;
    if (commit)
      for (int i = 0; i < PAGE_BYTES; i++)
        if (mask_reg[i])
        begin
          if (prog_id_reg)
            id_mem[i] <= page_buf[i];
          else
            mem[{prog_page_reg, 5'(i)}] <= page_buf[i];
        end
  end

  assign sda_out    = 1'b0;
  assign sda_oe     = oe_reg;
  assign write_busy = busy_reg;
  assign id_locked  = locked_reg;
  assign standby    = standby_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_decide(bus_state_t st);
    state_reg == st && scl_fall && !start_det && !stop_det && cnt_reg == BIT_ACK && !ackph_reg;
  endsequence

  sequence s_quiet;
    busy_reg && !commit;
  endsequence

  a_start_resets: assert property (start_det |=> state_reg == ST_DEV && !oe_reg && cnt_reg == BIT_ZERO)
    else $error("start did not reset the protocol logic");
  a_stop_ends: assert property (stop_det |=> state_reg == ST_IDLE && !oe_reg)
    else $error("stop did not end the operation");
  a_type_check: assert property (s_decide(ST_DEV) ##0 shift_reg[7:5] != 3'h5 |=> !oe_reg)
    else $error("foreign device type acknowledged");
  a_select_check: assert property (s_decide(ST_DEV) ##0 shift_reg[3:1] != cs_s |=> !oe_reg)
    else $error("chip select mismatch acknowledged");
  a_busy_nack: assert property (s_decide(ST_DEV) ##0 busy_reg |=> !oe_reg ##1 (!oe_reg || start_det))
    else $error("device answered while programming");
  a_match_ack: assert property (s_decide(ST_DEV) ##0 shift_reg[7:4] == TYPE_MAIN && shift_reg[3:1] == cs_s
                                && !busy_reg |=> oe_reg && ackph_reg)
    else $error("matching target byte not acknowledged");
  a_locked_nack: assert property (s_decide(ST_WDATA) ##0 is_id_reg && locked_reg |=> !oe_reg)
    else $error("locked id page data acknowledged");
  a_page_wrap: assert property (s_decide(ST_WDATA) ##0 !is_id_reg && addr_reg[4:0] == PAGE_LAST
                                |=> addr_reg[4:0] == 5'h00 && addr_reg[12:5] == $past(addr_reg[12:5]))
    else $error("page write address left its page");
  a_array_roll: assert property (do_load && !is_id_reg && addr_reg == ARRAY_LAST |=> addr_reg == 13'h0000)
    else $error("address counter did not roll over");
  a_write_time: assert property ($rose(busy_reg) |-> timer_reg == WRITE_CYCLES ##1 s_quiet[*3] ##0 busy_reg)
    else $error("write cycle length wrong");
  a_wp_block: assert property (stop_det && state_reg == ST_WDATA && wp_s && !busy_reg |=> !busy_reg)
    else $error("programming started under write protect");
  a_standby: assert property (state_reg == ST_IDLE && !busy_reg |=> standby_reg || state_reg != ST_IDLE)
    else $error("standby not shown when idle");

endmodule

// ---- verif/bus_controller_model.sv ----
// Purpose: behavioural two-wire bus controller that faces the eeprom target
// Assumes: 800 ns scl period, 8 core clocks; sda has a pull-up in the bench
// Notes:   moves its lines 1 ns after a core_clk rise; scl stands high between frames
`timescale 1ns/100ps
module bus_controller_model
(
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // data moves one clock after scl falls, sampled at the end of the high phase
  task automatic bit_xfer(input logic v, output logic s);
    wait_clk(1);
    sda_low = ~v;
    wait_clk(4);
    scl = 1'b1;
    wait_clk(3);
    s = sda;
    scl = 1'b0;
  endtask

  task automatic start_cond();
    if (scl === 1'b0)
    begin
      wait_clk(1);
      sda_low = 1'b0;
      wait_clk(4);
      scl = 1'b1;
      wait_clk(3);
    end
    sda_low = 1'b1;
    wait_clk(3);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    wait_clk(1);
    sda_low = 1'b1;
    wait_clk(4);
    scl = 1'b1;
    wait_clk(3);
    sda_low = 1'b0;
    wait_clk(4);
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask

  // give_ack low ends a read: no acknowledge, then the caller sends stop
  task automatic read_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, s);
      b[i] = s;
    end
    bit_xfer(~give_ack, s);
  endtask

  // clock until sda is seen high at the end of a high phase, then start in that high phase
  task automatic recover();
    for (int i = 0; i < 9; i++)
    begin
      wait_clk(5);
      scl = 1'b1;
      wait_clk(3);
      if (sda === 1'b1)
        break;
      scl = 1'b0;
    end
    sda_low = 1'b1;
    wait_clk(3);
    scl = 1'b0;
  endtask
endmodule

// ---- verif/testbench.sv ----
// Purpose: self-checking bench of the serial eeprom bus target
// Assumes: write cycle shortened to 512 core clocks
// Notes:   expected memory holds only written places; unwritten cells stay unknown
`timescale 1ns/100ps
`define check_eq(a, e) \
  begin \
    n_tests++; \
    if ((a) !== (e)) \
    begin \
      n_errors++; \
      $display("wrong value at %0t ns: got %h expected %h", $time, (a), (e)); \
    end \
  end
module testbench;
  import eeprom_target_pkg::*;
  localparam logic [15:0] WCYC = 16'h0200;
  logic       core_clk;
  logic       rst;
  logic       scl;
  logic       sda_low;
  logic       sda;
  logic       wp;
  logic [2:0] cs;
  logic       sda_out;
  logic       sda_oe;
  logic       write_busy;
  logic       id_locked;
  logic       standby;
  logic       ack;
  logic       s;
  logic       lock_exp;
  logic [7:0] rd;
  logic [7:0] exp_mem [8192];
  logic [7:0] exp_id [32];
  logic [12:0] pg;
  int         n_errors;
  int         n_tests;
  int         busy_run;
  int         busy_len;
  int         nb;

  // open drain wire with pull-up: low if either party pulls
  assign sda = ~(sda_low | (sda_oe & ~sda_out));

  eeprom_bus_target #(.WRITE_CYCLES(WCYC)) uut
  (
    .core_clk         (core_clk),
    .rst              (rst),
    .scl              (scl),
    .sda_in           (sda),
    .sda_out          (sda_out),
    .sda_oe           (sda_oe),
    .chip_select_bit0 (cs[0]),
    .chip_select_bit1 (cs[1]),
    .chip_select_bit2 (cs[2]),
    .write_protect    (wp),
    .write_busy       (write_busy),
    .id_locked        (id_locked),
    .standby          (standby)
  );

  bus_controller_model ctl
  (
    .core_clk (core_clk),
    .sda      (sda),
    .scl      (scl),
    .sda_low  (sda_low)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (write_busy === 1'b1)
      busy_run <= busy_run + 1;
    else if (busy_run != 0)
    begin
      busy_len <= busy_run;
      busy_run <= 0;
    end

  function automatic logic [7:0] dev(input logic [3:0] t, input logic rw);
    return {t, cs, rw};
  endfunction

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic addr_phase(input logic [3:0] t, input logic [12:0] a);
    ctl.start_cond();
    ctl.write_byte(dev(t, 1'b0), ack);
    `check_eq(ack, 1'b1)
    ctl.write_byte({3'h0, a[12:8]}, ack);
    `check_eq(ack, 1'b1)
    ctl.write_byte(a[7:0], ack);
    `check_eq(ack, 1'b1)
  endtask

  // acknowledge polling; the first poll must land inside the write cycle
  task automatic wait_write();
    int i;
    for (i = 0; i < 40; i++)
    begin
      ctl.start_cond();
      ctl.write_byte(dev(TYPE_MAIN, 1'b0), ack);
      if (ack === 1'b1)
        break;
    end
    `check_eq(i > 0 && i < 40, 1'b1)
    `check_eq(write_busy, 1'b0)
    `check_eq(busy_len == int'(WCYC), 1'b1)
    ctl.stop_cond();
    ctl.wait_clk(2);
    `check_eq(standby, 1'b1)
  endtask

  task automatic write_seq(input logic [3:0] t, input logic [12:0] a, input int n, input logic [7:0] orm);
    logic [7:0] d;
    logic       acked;
    logic       prog;
    acked = !(t == TYPE_ID && !a[10] && lock_exp);
    prog = !wp && acked;
    addr_phase(t, a);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom) | orm;
      ctl.write_byte(d, ack);
      `check_eq(ack, acked)
      if (!acked)
        break;
      if (prog && t == TYPE_MAIN)
        exp_mem[{a[12:5], 5'(a[4:0] + i)}] = d;
      if (prog && t == TYPE_ID && !a[10])
        exp_id[5'(a[4:0] + i)] = d;
    end
    ctl.stop_cond();
    ctl.wait_clk(2);
    `check_eq(write_busy, prog)
    if (prog)
      wait_write();
    if (prog && t == TYPE_ID && a[10])
      lock_exp = 1'b1;
  endtask

  task automatic read_seq(input logic [3:0] t, input logic [12:0] a, input int n, input logic rnd);
    logic [7:0] e;
    if (rnd)
      addr_phase(t, a);
    ctl.start_cond();
    ctl.write_byte(dev(t, 1'b1), ack);
    `check_eq(ack, 1'b1)
    for (int i = 0; i < n; i++)
    begin
      ctl.read_byte(i < n - 1, rd);
      e = (t == TYPE_ID) ? exp_id[5'(a[4:0] + i)] : exp_mem[13'(a + i)];
      `check_eq(rd, e)
    end
    ctl.stop_cond();
  endtask

  initial
  begin
    #5_000_000;
    n_errors++;
    end_sim();
  end

  initial
  begin
    void'($urandom(56));
    n_errors = 0;
    n_tests = 0;
    busy_run = 0;
    busy_len = 0;
    lock_exp = 1'b0;
    wp = 1'b0;
    cs = 3'($urandom);
    rst = 1'b1;
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    ctl.wait_clk(4);
    `check_eq({standby, write_busy, id_locked, sda_oe}, 4'h8)
    // wrong type code, then every mismatching select value
    for (int k = 0; k < 8; k++)
    begin
      ctl.start_cond();
      ctl.write_byte(k == 0 ? {4'h5, cs, 1'b0} : {TYPE_MAIN, cs ^ 3'(k), 1'b1}, ack);
      `check_eq(ack, 1'b0)
      ctl.stop_cond();
    end
    // 34 bytes from offset 28: wraps inside the page and overwrites
    pg = {8'($urandom), 5'h00};
    write_seq(TYPE_MAIN, pg | 13'h001C, 34, 8'h00);
    read_seq(TYPE_MAIN, pg, 5, 1'b1);
    read_seq(TYPE_MAIN, pg + 13'h0005, 2, 1'b0);
    write_seq(TYPE_MAIN, ARRAY_LAST, 1, 8'h00);
    write_seq(TYPE_MAIN, 13'h0000, 1, 8'h00);
    read_seq(TYPE_MAIN, ARRAY_LAST, 2, 1'b1);
    ctl.wait_clk(1);
    wp = 1'b1;
    write_seq(TYPE_MAIN, pg, 2, 8'h00);
    wp = 1'b0;
    read_seq(TYPE_MAIN, pg, 2, 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      // read back only the bytes written: unwritten cells are unknown on both sides
      pg = {8'($urandom), 5'($urandom % 28)};
      nb = 1 + $urandom % 4;
      write_seq(TYPE_MAIN, pg, nb, 8'h00);
      read_seq(TYPE_MAIN, pg, nb, 1'b1);
    end
    write_seq(TYPE_ID, {2'($urandom), 1'b0, 5'($urandom), 5'h1D}, 3, 8'h00);
    read_seq(TYPE_ID, {8'($urandom), 5'h1D}, 3, 1'b1);
    write_seq(TYPE_ID, 13'h0400, 1, 8'h02);
    `check_eq(id_locked, lock_exp)
    write_seq(TYPE_ID, 13'h0003, 2, 8'h00);
    read_seq(TYPE_ID, 13'h001D, 3, 1'b1);
    // abort a read after three bits, recover and address again
    addr_phase(TYPE_MAIN, 13'h0000);
    ctl.start_cond();
    ctl.write_byte(dev(TYPE_MAIN, 1'b1), ack);
    for (int k = 0; k < 3; k++)
      ctl.bit_xfer(1'b1, s);
    ctl.recover();
    ctl.write_byte(dev(TYPE_MAIN, 1'b0), ack);
    `check_eq(ack, 1'b1)
    ctl.stop_cond();
    end_sim();
  end
endmodule
